// ---- hdl/card16_cycle_timing_generator.sv ----
// Purpose: times 16-bit card memory and I/O cycles in bus clocks, routes card audio and interrupts
// Assumes: AXI4-Lite slave on aclk, card inputs synchronous to aclk
// Notes:   software loads address/data, then writes the cycle command to start one card cycle
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`include "card16_regs.svh"
`default_nettype none
module card16_cycle_timing_generator
  import card16_pkg::*;
#(
  parameter int ADDR_W = 8,  // axi address width
  parameter int CA_W   = 26  // card address width
) (
  input  wire logic              aclk,          // bus clock
  input  wire logic              aresetn,       // sync reset, low active
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
  input  wire logic              s_axi_awvalid, // write address valid
  output logic                   s_axi_awready, // write address ready
  input  wire logic [31:0]       s_axi_wdata,   // write data
  input  wire logic [3:0]        s_axi_wstrb,   // byte enables
  input  wire logic              s_axi_wvalid,  // write data valid
  output logic                   s_axi_wready,  // write data ready
  output logic [1:0]             s_axi_bresp,   // write response
  output logic                   s_axi_bvalid,  // write response valid
  input  wire logic              s_axi_bready,  // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
  input  wire logic              s_axi_arvalid, // read address valid
  output logic                   s_axi_arready, // read address ready
  output logic [31:0]            s_axi_rdata,   // read data
  output logic [1:0]             s_axi_rresp,   // read response
  output logic                   s_axi_rvalid,  // read data valid
  input  wire logic              s_axi_rready,  // read data ready
  output logic [CA_W-1:0]        card_addr,     // card address
  output logic                   card_reg_n,    // register space select
  output logic                   card_ce_n,     // card enable
  output logic                   card_oe_n,     // memory read strobe
  output logic                   card_we_n,     // memory write strobe
  output logic                   card_iord_n,   // i/o read strobe
  output logic                   card_iowr_n,   // i/o write strobe
  output logic [15:0]            card_data_o,   // card data out
  output logic                   card_data_oe_n,// card data drive, low drives
  input  wire logic [15:0]       card_data_i,   // card data in
  input  wire logic              card_wait_n,   // card wait, low extends
  input  wire logic              card_bvd2,     // card audio level
  input  wire logic              card_ireq_n,   // card interrupt, low active
  input  wire logic              card_stschg,   // card status change
  output logic                   speaker_output,// audio to speaker
  output logic [15:3]            isa_irq        // isa interrupt lines
);

  // isa irq number to one-hot over lines 3..15, none if out of range
  function automatic logic [12:0] irq_onehot(input logic [3:0] num);
    logic [12:0] v;
    v = 13'h0000;
    if (num >= 4'h3) begin
      v[num - 4'h3] = 1'b1;
    end
    return v;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // bus side state
  logic [5:0]      mem_cfg_r, mem_cfg_nxt;     // memory window wait settings
  logic [5:0]      io_cfg_r, io_cfg_nxt;       // i/o window wait settings
  logic [CA_W-1:0] addr_reg_r, addr_reg_nxt;   // address for next cycle
  logic [15:0]     wr_data_r, wr_data_nxt;     // write data for next cycle
  logic [7:0]      route_r, route_nxt;         // irq routing
  logic            awready_r, awready_nxt;
  logic            wready_r, wready_nxt;
  logic            bvalid_r, bvalid_nxt;
  logic [1:0]      bresp_r, bresp_nxt;
  logic            arready_r, arready_nxt;
  logic            rvalid_r, rvalid_nxt;
  logic [1:0]      rresp_r, rresp_nxt;
  logic [31:0]     rdata_r, rdata_nxt;
  logic            start;                      // cycle command accepted
  logic [3:0]      cmd;                        // command bits of start

  // cycle engine state
  cyc_state_t      st_r, st_nxt;
  count_t          su_cnt_r, su_cnt_nxt;       // setup phase counter
  count_t          act_cnt_r, act_cnt_nxt;     // active phase counter
  count_t          hold_cnt_r, hold_cnt_nxt;   // hold phase counter
  logic [3:0]      cur_cmd_r, cur_cmd_nxt;     // command of cycle under way
  logic [CA_W-1:0] ca_r, ca_nxt;
  logic            reg_n_r, reg_n_nxt;
  logic            ce_n_r, ce_n_nxt;
  logic            strobe_r, strobe_nxt;       // command strobe asserted
  logic [15:0]     dout_r, dout_nxt;
  logic            doe_n_r, doe_n_nxt;
  logic [15:0]     rd_data_r, rd_data_nxt;     // captured read data
  logic            done_r, done_nxt;           // cycle finished
  logic            spk_r;
  logic [12:0]     irq_r, irq_nxt;

  // selected table entries
  logic [1:0]      wait_sel;
  logic            zws;
  count_t          su_sel, act_sel, hold_sel;
  logic [31:0]     wmerged;

  // pick window settings and table entries for the command
  always_comb begin
    wait_sel = cmd[`FLD_CMD_IO] ? {1'b0, io_cfg_r[`FLD_WAIT_LO]} : mem_cfg_r[`FLD_WAIT_HI:`FLD_WAIT_LO];
    zws      = cmd[`FLD_CMD_IO] ? io_cfg_r[`FLD_ZWS] : mem_cfg_r[`FLD_ZWS];
    // only the timing_select 01 table exists, so every select value uses it
    if (cmd[`FLD_CMD_IO]) begin
      su_sel   = `SU_IO;
      hold_sel = `HOLD_IO;
    end else begin
      su_sel   = wait_sel[1] ? `SU_MEM_HI : `SU_MEM_LO;
      hold_sel = wait_sel[1] ? `HOLD_MEM_HI : `HOLD_MEM_LO;
    end
    if (!cmd[`FLD_CMD_WIDE]) begin
      if (wait_sel != 2'b00) act_sel = `ACT8_WAIT;
      else if (zws) act_sel = `ACT8_ZWS;
      else act_sel = `ACT8_NOWS;
    end else if (cmd[`FLD_CMD_IO]) begin
      act_sel = wait_sel[0] ? `ACT16IO_W1 : `ACT16IO_W0;
    end else begin
      unique case (wait_sel)
        2'b00:   act_sel = zws ? `ACT16M_ZWS : `ACT16M_W0;
        2'b01:   act_sel = `ACT16M_W1;
        2'b10:   act_sel = `ACT16M_W2;
        2'b11:   act_sel = `ACT16M_W3;
      endcase
    end
  end

  // axi4-lite slave: write taken when address and data are both offered
  always_comb begin
    mem_cfg_nxt  = mem_cfg_r;
    io_cfg_nxt   = io_cfg_r;
    addr_reg_nxt = addr_reg_r;
    wr_data_nxt  = wr_data_r;
    route_nxt    = route_r;
    awready_nxt  = 1'b0;
    wready_nxt   = 1'b0;
    bvalid_nxt   = bvalid_r && !s_axi_bready;
    bresp_nxt    = bresp_r;
    arready_nxt  = 1'b0;
    rvalid_nxt   = rvalid_r && !s_axi_rready;
    rresp_nxt    = rresp_r;
    rdata_nxt    = rdata_r;
    start        = 1'b0;
    cmd          = cur_cmd_r;
    wmerged      = 32'h0000_0000;
    // handshake one cycle, then write in the cycle ready is seen
    if (s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r) begin
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (awready_r) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = 2'b00;
      unique case (s_axi_awaddr)
        `OFS_MEM_CFG: begin
          wmerged     = merge({26'h0, mem_cfg_r}, s_axi_wdata, s_axi_wstrb);
          mem_cfg_nxt = wmerged[5:0];
        end
        `OFS_IO_CFG: begin
          wmerged    = merge({26'h0, io_cfg_r}, s_axi_wdata, s_axi_wstrb);
          io_cfg_nxt = wmerged[5:0];
        end
        `OFS_CARD_ADDR: begin
          wmerged      = merge({{(32-CA_W){1'b0}}, addr_reg_r}, s_axi_wdata, s_axi_wstrb);
          addr_reg_nxt = wmerged[CA_W-1:0];
        end
        `OFS_WR_DATA: begin
          wmerged     = merge({16'h0, wr_data_r}, s_axi_wdata, s_axi_wstrb);
          wr_data_nxt = wmerged[15:0];
        end
        `OFS_CYCLE_CMD: begin
          // a command while a cycle runs is ignored
          if (st_r == ST_IDLE && s_axi_wstrb[0]) begin
            start = 1'b1;
            cmd   = s_axi_wdata[3:0];
          end
        end
        `OFS_IRQ_ROUTE: begin
          wmerged   = merge({24'h0, route_r}, s_axi_wdata, s_axi_wstrb);
          route_nxt = wmerged[7:0];
        end
        `OFS_STATUS, `OFS_RD_DATA: ;
        default: bresp_nxt = 2'b10;
      endcase
    end
    // read: one-cycle arready, data the next cycle
    if (s_axi_arvalid && !arready_r && !rvalid_r) begin
      arready_nxt = 1'b1;
    end
    if (arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'b00;
      unique case (s_axi_araddr)
        `OFS_MEM_CFG:   rdata_nxt = {26'h0, mem_cfg_r};
        `OFS_IO_CFG:    rdata_nxt = {26'h0, io_cfg_r};
        `OFS_CARD_ADDR: rdata_nxt = {{(32-CA_W){1'b0}}, addr_reg_r};
        `OFS_WR_DATA:   rdata_nxt = {16'h0, wr_data_r};
        `OFS_CYCLE_CMD: rdata_nxt = {28'h0, cur_cmd_r};
        `OFS_STATUS:    rdata_nxt = {30'h0, done_r, st_r != ST_IDLE};
        `OFS_RD_DATA:   rdata_nxt = {16'h0, rd_data_r};
        `OFS_IRQ_ROUTE: rdata_nxt = {24'h0, route_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = 2'b10;
        end
      endcase
    end
  end

  // bus side registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_cfg_r  <= `CFG_RESET;
      io_cfg_r   <= `CFG_RESET;
      addr_reg_r <= '0;
      wr_data_r  <= 16'h0000;
      route_r    <= `IRQ_ROUTE_RST;
      awready_r  <= 1'b0;
      wready_r   <= 1'b0;
      bvalid_r   <= 1'b0;
      bresp_r    <= 2'b00;
      arready_r  <= 1'b0;
      rvalid_r   <= 1'b0;
      rresp_r    <= 2'b00;
      rdata_r    <= 32'h0000_0000;
    end else begin
      mem_cfg_r  <= mem_cfg_nxt;
      io_cfg_r   <= io_cfg_nxt;
      addr_reg_r <= addr_reg_nxt;
      wr_data_r  <= wr_data_nxt;
      route_r    <= route_nxt;
      awready_r  <= awready_nxt;
      wready_r   <= wready_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      arready_r  <= arready_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // card cycle engine: setup, active, hold, each on its own counter
  always_comb begin
    st_nxt       = st_r;
    su_cnt_nxt   = su_cnt_r;
    act_cnt_nxt  = act_cnt_r;
    hold_cnt_nxt = hold_cnt_r;
    cur_cmd_nxt  = cur_cmd_r;
    ca_nxt       = ca_r;
    reg_n_nxt    = reg_n_r;
    ce_n_nxt     = ce_n_r;
    strobe_nxt   = strobe_r;
    dout_nxt     = dout_r;
    doe_n_nxt    = doe_n_r;
    rd_data_nxt  = rd_data_r;
    done_nxt     = done_r;
    unique case (st_r)
      ST_IDLE: begin
        if (start) begin
          // address, select and write data go out with the setup count
          st_nxt      = ST_SETUP;
          cur_cmd_nxt = cmd;
          ca_nxt      = addr_reg_r;
          reg_n_nxt   = !cmd[`FLD_CMD_REG];
          ce_n_nxt    = 1'b0;
          dout_nxt    = wr_data_r;
          doe_n_nxt   = !cmd[`FLD_CMD_WRITE];
          su_cnt_nxt  = su_sel + `SU_EXTRA;
          done_nxt    = 1'b0;
        end
      end
      ST_SETUP: begin
        if (su_cnt_r == 5'h01) begin
          st_nxt      = ST_ACTIVE;
          strobe_nxt  = 1'b1;
          act_cnt_nxt = act_sel;
        end else begin
          su_cnt_nxt = su_cnt_r - 5'h01;
        end
      end
      ST_ACTIVE: begin
        if (act_cnt_r > 5'h01) begin
          act_cnt_nxt = act_cnt_r - 5'h01;
        end else if (card_wait_n) begin
          // the strobe rises only once wait is seen released
          st_nxt       = ST_HOLD;
          strobe_nxt   = 1'b0;
          rd_data_nxt  = cur_cmd_r[`FLD_CMD_WRITE] ? rd_data_r : card_data_i;
          hold_cnt_nxt = hold_sel + `HOLD_EXTRA;
        end
      end
      ST_HOLD: begin
        if (hold_cnt_r == 5'h01) begin
          st_nxt    = ST_IDLE;
          ce_n_nxt  = 1'b1;
          reg_n_nxt = 1'b1;
          doe_n_nxt = 1'b1;
          done_nxt  = 1'b1;
        end else begin
          hold_cnt_nxt = hold_cnt_r - 5'h01;
        end
      end
    endcase
  end

  // engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r       <= ST_IDLE;
      su_cnt_r   <= 5'h00;
      act_cnt_r  <= 5'h00;
      hold_cnt_r <= 5'h00;
      cur_cmd_r  <= 4'h0;
      ca_r       <= '0;
      reg_n_r    <= 1'b1;
      ce_n_r     <= 1'b1;
      strobe_r   <= 1'b0;
      dout_r     <= 16'h0000;
      doe_n_r    <= 1'b1;
      rd_data_r  <= 16'h0000;
      done_r     <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      su_cnt_r   <= su_cnt_nxt;
      act_cnt_r  <= act_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      cur_cmd_r  <= cur_cmd_nxt;
      ca_r       <= ca_nxt;
      reg_n_r    <= reg_n_nxt;
      ce_n_r     <= ce_n_nxt;
      strobe_r   <= strobe_nxt;
      dout_r     <= dout_nxt;
      doe_n_r    <= doe_n_nxt;
      rd_data_r  <= rd_data_nxt;
      done_r     <= done_nxt;
    end
  end

  // interrupt routing, one line per isa irq
  always_comb begin
    irq_nxt = (irq_onehot(route_r[`FLD_IREQ_LO +: 4]) & {13{!card_ireq_n}})
            | (irq_onehot(route_r[`FLD_STS_LO +: 4]) & {13{card_stschg}});
  end

  // audio and interrupt pass-through, one clock late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spk_r <= 1'b1;
      irq_r <= 13'h0000;
    end else begin
      spk_r <= card_bvd2;
      irq_r <= irq_nxt;
    end
  end

  // strobe decode straight from state flops is avoided: strobes use their own bits
  logic oe_n_r, we_n_r, iord_n_r, iowr_n_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_n_r   <= 1'b1;
      we_n_r   <= 1'b1;
      iord_n_r <= 1'b1;
      iowr_n_r <= 1'b1;
    end else begin
      oe_n_r   <= !(strobe_nxt && !cur_cmd_nxt[`FLD_CMD_IO] && !cur_cmd_nxt[`FLD_CMD_WRITE]);
      we_n_r   <= !(strobe_nxt && !cur_cmd_nxt[`FLD_CMD_IO] && cur_cmd_nxt[`FLD_CMD_WRITE]);
      iord_n_r <= !(strobe_nxt && cur_cmd_nxt[`FLD_CMD_IO] && !cur_cmd_nxt[`FLD_CMD_WRITE]);
      iowr_n_r <= !(strobe_nxt && cur_cmd_nxt[`FLD_CMD_IO] && cur_cmd_nxt[`FLD_CMD_WRITE]);
    end
  end

  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rresp    = rresp_r;
  assign s_axi_rdata    = rdata_r;
  assign card_addr      = ca_r;
  assign card_reg_n     = reg_n_r;
  assign card_ce_n      = ce_n_r;
  assign card_oe_n      = oe_n_r;
  assign card_we_n      = we_n_r;
  assign card_iord_n    = iord_n_r;
  assign card_iowr_n    = iowr_n_r;
  assign card_data_o    = dout_r;
  assign card_data_oe_n = doe_n_r;
  assign speaker_output = spk_r;
  assign isa_irq        = irq_r;

endmodule
`default_nettype wire

// ---- hdl/card16_pkg.sv ----
// Purpose: types of the card cycle timing generator
// Assumes: nothing beyond the register header
// Notes:   one-hot cycle states
`default_nettype none
package card16_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETUP  = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_HOLD   = 4'b1000
  } cyc_state_t;
  typedef logic [4:0] count_t;
endpackage
`default_nettype wire

// ---- hdl/card16_regs.svh ----
// Purpose: register map, field positions, reset values and cycle counts of the card cycle timing generator
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   counts are in bus clock cycles
`ifndef CARD16_REGS_SVH
`define CARD16_REGS_SVH
// register byte offsets
`define OFS_MEM_CFG    8'h00
`define OFS_IO_CFG     8'h04
`define OFS_CARD_ADDR  8'h08
`define OFS_WR_DATA    8'h0C
`define OFS_CYCLE_CMD  8'h10
`define OFS_STATUS     8'h14
`define OFS_RD_DATA    8'h18
`define OFS_IRQ_ROUTE  8'h1C
// window config fields
`define FLD_WAIT_LO    0
`define FLD_WAIT_HI    1
`define FLD_ZWS        2
`define FLD_TS_LO      4
`define FLD_TS_HI      5
`define CFG_RESET      6'h10
// cycle command fields
`define FLD_CMD_WRITE  0
`define FLD_CMD_IO     1
`define FLD_CMD_WIDE   2
`define FLD_CMD_REG    3
// irq route fields
`define FLD_IREQ_LO    0
`define FLD_STS_LO     4
`define IRQ_ROUTE_RST  8'h00
// address setup counts
`define SU_IO          5'h03
`define SU_MEM_LO      5'h02
`define SU_MEM_HI      5'h04
`define SU_EXTRA       5'h02
// command active counts, 8-bit
`define ACT8_NOWS      5'h13
`define ACT8_WAIT      5'h17
`define ACT8_ZWS       5'h07
// command active counts, 16-bit
`define ACT16IO_W0     5'h07
`define ACT16IO_W1     5'h0B
`define ACT16M_W0      5'h09
`define ACT16M_W1      5'h0D
`define ACT16M_W2      5'h11
`define ACT16M_W3      5'h17
`define ACT16M_ZWS     5'h05
// address hold counts
`define HOLD_IO        5'h02
`define HOLD_MEM_LO    5'h02
`define HOLD_MEM_HI    5'h03
`define HOLD_EXTRA     5'h01
`endif

// ---- test/card16_assertions.sv ----
// Purpose: concurrent checks on card strobe phases and audio path
// Assumes: strobes, enable and wait active low
// Notes:   exact table counts are left to the bench
`default_nettype none
module card16_assertions #(
  parameter int CA_W = 26 // card address width
) (
  input wire logic            aclk,           // clock
  input wire logic            aresetn,        // sync reset
  input wire logic [CA_W-1:0] card_addr,      // address
  input wire logic            card_reg_n,     // reg select
  input wire logic            card_ce_n,      // enable
  input wire logic            card_oe_n,      // mem read
  input wire logic            card_we_n,      // mem write
  input wire logic            card_iord_n,    // io read
  input wire logic            card_iowr_n,    // io write
  input wire logic            card_data_oe_n, // data drive
  input wire logic            card_wait_n,    // card wait
  input wire logic            card_bvd2,      // card audio
  input wire logic            speaker_output  // speaker
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic  strb_n = card_oe_n & card_we_n & card_iord_n & card_iowr_n; // no strobe low
  logic [5:0] su_r, su_nxt;  // edges with enable low
  logic [5:0] act_r, act_nxt; // edges with a strobe low
  // restart when idle; six bits cover the longest waited cycle
  always_comb begin
    su_nxt  = card_ce_n ? 6'h00 : su_r + 6'h01;
    act_nxt = strb_n ? 6'h00 : act_r + 6'h01;
  end
  // register only
  always_ff @(posedge aclk) begin
    su_r  <= aresetn ? su_nxt : 6'h00;
    act_r <= aresetn ? act_nxt : 6'h00;
  end
  AST_SETUP: assert property ($fell(strb_n) |-> su_r inside {6'h04, 6'h05, 6'h06})
    else $error("setup count");
  AST_ACTIVE: assert property ($rose(strb_n) |-> act_r inside {6'h05, 6'h07, 6'h09, 6'h0B,
    6'h0D, 6'h11, 6'h13, 6'h17} || !$past(card_wait_n) || !$past(card_wait_n, 2) || !$past(card_wait_n, 3))
    else $error("active count");
  AST_HOLD: assert property ($rose(strb_n) |-> (!card_ce_n) [*3] ##[1:2] card_ce_n)
    else $error("hold count");
  AST_ADDR: assert property (!card_ce_n && !$past(card_ce_n) |-> $stable(card_addr) && $stable(card_reg_n))
    else $error("address moved");
  AST_ONE: assert property (!strb_n |-> !card_ce_n &&
    $onehot0(~{card_oe_n, card_we_n, card_iord_n, card_iowr_n}))
    else $error("strobe set");
  AST_DIR: assert property (!strb_n |-> card_data_oe_n == (card_we_n && card_iowr_n))
    else $error("data direction");
  AST_WAIT: assert property (!strb_n && !card_wait_n |=> !strb_n)
    else $error("strobe left wait");
  AST_SPKR: assert property ($past(aresetn) |-> speaker_output == $past(card_bvd2))
    else $error("speaker level");
endmodule
bind card16_cycle_timing_generator card16_assertions #(.CA_W(CA_W)) card16_assertions_i (.aclk, .aresetn,
  .card_addr, .card_reg_n, .card_ce_n, .card_oe_n, .card_we_n, .card_iord_n, .card_iowr_n, .card_data_oe_n,
  .card_wait_n, .card_bvd2, .speaker_output);
`default_nettype wire

// ---- test/card16_card_model.sv ----
// Purpose: behavioural card answering memory and i/o cycles
// Assumes: strobes active low, seen on the bus clock
// Notes:   a released data bus toggles every cycle
`default_nettype none
module card16_card_model (
  input  wire logic        aclk,        // clock
  input  wire logic [25:0] card_addr,   // address
  input  wire logic        card_ce_n,   // enable
  input  wire logic        rd_n,        // any read strobe
  input  wire logic        wr_n,        // any write strobe
  input  wire logic [15:0] card_data_o, // host data
  input  wire logic        wait_en,     // stretch strobes
  output logic      [15:0] card_data_i, // card data
  output logic             card_wait_n, // low holds strobe
  output logic      [15:0] last_wr      // last write
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] low_cnt = 6'h00; // edges with strobe low
  initial card_data_i = 16'h0000;
  // answers move just after the edge
  always @(posedge aclk) begin
    low_cnt <= (rd_n & wr_n) ? 6'h00 : low_cnt + 6'h01;
    card_wait_n <= !(wait_en && !(rd_n & wr_n) && low_cnt < 6'h1E);
    if (!card_ce_n && !rd_n)
      card_data_i <= card_addr[15:0] ^ 16'hA5A5; // word tied to address
    else
      card_data_i <= ~card_data_i; // never a stale value
    if (!card_ce_n && !wr_n)
      last_wr <= card_data_o;
  end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Purpose: self-checking bench of the card cycle timing generator
// Assumes: 50 MHz clock, card model on the far side
// Notes:   phase lengths measured in sampled edges
`include "card16_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0;                  // clock, reset
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;   // addresses
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;          // data
  logic [3:0]  s_axi_wstrb = 4'hF;                           // all lanes
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;                  // responses
  logic [25:0] card_addr, addr_seen, ca;                     // card address
  logic [15:0] card_data_o, card_data_i, last_wr, x;         // card data
  logic        card_reg_n, card_ce_n, card_oe_n, card_we_n, card_iord_n, card_iowr_n;
  logic        card_data_oe_n, card_wait_n, speaker_output, reg_seen;
  logic        card_bvd2 = 1'b1, card_ireq_n = 1'b1, card_stschg = 1'b0, wait_en = 1'b0;
  logic        ce_q = 1'b1, st_q = 1'b1;                     // last samples
  logic [15:3] isa_irq;                                      // isa lines
  logic [27:0] e;                                            // table entry
  logic [3:0]  cmd, strb_seen;                               // command, strobes
  logic [7:0]  rt [3] = '{8'h95, 8'hF3, 8'h21};              // irq routes
  int          cyc = 0, n_cyc = 0, t_ce, t_fall, t_rise, su_m, act_m, hd_m;
  int          n_errors = 0, total_checks = 0;
  wire logic   strb_n = card_oe_n & card_we_n & card_iord_n & card_iowr_n;
  // config, command, setup+2, active, hold+1
  logic [27:0] tbl [15] = '{28'h1044093, 28'h11C40D3, 28'h1246114, 28'h1346174, 28'h14C4053,
    28'h1004133, 28'h1184173, 28'h1404073, 28'h1206174, 28'h1065073,
    28'h11650B3, 28'h14E5073, 28'h1025133, 28'h11A5173, 28'h1425073};
  card16_cycle_timing_generator card16_cycle_timing_generator_i (.*);
  card16_card_model card16_card_model_i (.aclk, .card_addr, .card_ce_n, .rd_n(card_oe_n & card_iord_n),
    .wr_n(card_we_n & card_iowr_n), .card_data_o, .wait_en, .card_data_i, .card_wait_n, .last_wr);
  always #10 aclk = ~aclk; // 50 MHz
  // phase lengths of every card cycle
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (ce_q && !card_ce_n) begin
      t_ce = cyc;
      n_cyc = n_cyc + 1;
    end
    if (!ce_q && card_ce_n) hd_m = cyc - t_rise;
    if (st_q && !strb_n) begin
      su_m = cyc - t_ce;
      t_fall = cyc;
      strb_seen = {card_oe_n, card_we_n, card_iord_n, card_iowr_n};
      {reg_seen, addr_seen} = {card_reg_n, card_addr};
    end
    if (!st_q && strb_n) begin
      act_m = cyc - t_fall;
      t_rise = cyc;
    end
    ce_q = card_ce_n;
    st_q = strb_n;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // address and data may be taken on different edges
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw = 1'b1, w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk); // no strobe set twice in one step
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    {rs, rd} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // start one card cycle, optionally poke again while busy, then poll
  task automatic run_cycle(input logic [3:0] c, input logic twice);
    int n0 = n_cyc;
    axi_wr(`OFS_CYCLE_CMD, {28'h0, c}, r);
    if (twice) axi_wr(`OFS_CYCLE_CMD, {28'h0, c}, r);
    do axi_rd(`OFS_STATUS, d, r); while (d[0] !== 1'b0);
    chk(d, 32'h2, "done status");
    chk(n_cyc - n0, 1, "cycle count");
  endtask
  task automatic check_read();
    axi_rd(`OFS_RD_DATA, d, r);
    chk(d, {16'h0, ca[15:0] ^ 16'hA5A5}, "read data");
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    final_report();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`OFS_MEM_CFG, d, r);
    chk(d, {26'h0, `CFG_RESET}, "mem cfg reset");
    axi_rd(`OFS_IO_CFG, d, r);
    chk(d, {26'h0, `CFG_RESET}, "io cfg reset");
    axi_rd(`OFS_IRQ_ROUTE, d, r);
    chk(d, 32'h0, "route reset");
    axi_rd(8'h20, d, r);
    chk({r, d[29:0]}, 32'h80000000, "unmapped read");
    axi_wr(8'h24, 32'hFFFFFFFF, r);
    chk(r, 2'b10, "unmapped write");
    $display("test registers done");
    // every table entry; odd rows write, even rows read
    for (int i = 0; i < 15; i++) begin
      e = tbl[i];
      cmd = {e[19:17], i[0]};
      ca = 26'h2345600 + 26'(i);
      axi_wr(e[17] ? `OFS_IO_CFG : `OFS_MEM_CFG, {24'h0, e[27:20]}, r);
      axi_wr(`OFS_CARD_ADDR, {6'h0, ca}, r);
      axi_wr(`OFS_WR_DATA, {16'h0, ~ca[15:0]}, r);
      run_cycle(cmd, i == 0);
      chk(su_m, e[15:12], "setup");
      chk(act_m, e[11:4], "active");
      chk(hd_m, e[3:0], "hold");
      chk(strb_seen, 4'(~(4'b1000 >> cmd[1:0])), "strobe");
      chk({reg_seen, addr_seen}, {!cmd[3], ca}, "address");
      if (cmd[0])
        chk(last_wr, 16'(~ca[15:0]), "write data");
      else
        check_read();
    end
    $display("test timing done");
    axi_wr(`OFS_MEM_CFG, 32'h10, r);
    wait_en <= 1'b1;
    run_cycle(4'h4, 1'b0);
    chk(act_m >= 31 && act_m <= 34, 1, "wait stretch");
    check_read();
    wait_en <= 1'b0;
    $display("test wait done");
    card_bvd2 <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(speaker_output, 1'b0, "speaker low");
    card_bvd2 <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(speaker_output, 1'b1, "speaker high");
    foreach (rt[k]) begin
      axi_wr(`OFS_IRQ_ROUTE, {24'h0, rt[k]}, r);
      x = 16'h0;
      if (rt[k][3:0] > 4'h2) x[rt[k][3:0]] = 1'b1;
      card_ireq_n <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(isa_irq, x[15:3], "card irq");
      if (rt[k][7:4] > 4'h2) x[rt[k][7:4]] = 1'b1;
      card_stschg <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(isa_irq, x[15:3], "status irq");
      {card_ireq_n, card_stschg} <= 2'b10;
      repeat (2) @(posedge aclk);
    end
    $display("test audio and irq done");
    final_report();
  end
endmodule
`default_nettype wire
